// [design/rmc_consts.vh]
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH
// instruction codes of the slave port selecting each register
`define RMC_IR_W          3
`define RMC_IR_PADSEL     3'h1
`define RMC_IR_PADDIS     3'h2
`define RMC_IR_ANAOUT     3'h3
`define RMC_IR_TSTMODE    3'h4
`define RMC_REG_W         8
`define RMC_RST_VAL       8'h00
// test pad selection fields
`define RMC_PAD1_HI       7
`define RMC_PAD1_LO       4
`define RMC_PAD2_HI       3
`define RMC_PAD2_LO       0
// pad disable bits
`define RMC_DIS_START     6
`define RMC_DIS_SPEAK     5
`define RMC_DIS_PLL       4
`define RMC_DIS_DATA1     3
`define RMC_DIS_DATA0     2
`define RMC_DIS_MARKER    1
`define RMC_DIS_CLK       0
// analog output control bits
`define RMC_ANA_GRP_HI    7
`define RMC_ANA_GRP_LO    6
`define RMC_ANA_MUX       5
`define RMC_ANA_RDDLY     4
`define RMC_ANA_NOCLP     3
`define RMC_ANA_CMDGEN    2
`define RMC_ANA_RATE      1
`define RMC_ANA_DUAL      0
// test mode bits
`define RMC_TM_PADEN      7
`define RMC_TM_DISCLINE   6
`define RMC_TM_GATECK     5
`define RMC_TM_MUXSCAN    3
`define RMC_TM_DISCSCAN   2
`define RMC_TM_SCAN       1
`define RMC_TM_AUTOSCAN   0
// main clock divider for pad 2 code 7
`define RMC_DIV_W         4
`define RMC_DIV_TOP       4'hF
`define RMC_DIV_HALF      4'h7
`endif

// [design/rmc_pad_mux.v]
`timescale 1ns/1ps
`include "rmc_consts.vh"
// 16-way registered selector for one test pad
module rmc_pad_mux (
  // clock and reset
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  // selection
  input  wire [3:0]  code_i,
  input  wire        enable_i,
  input  wire [15:0] sources_i,
  // pad
  output reg         pad_o
);
  // a disabled pad idles low so a stale code never shows
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= 1'b0;
    end else begin
      pad_o <= enable_i & sources_i[code_i];
    end
  end
endmodule

// [design/rmc_readout_cfg.v]
`timescale 1ns/1ps
`include "rmc_consts.vh"
// Summary of operation
// - an 8-bit selection register holds the pad 1 code in bits 7-4 and pad 2 code in bits 3-0.
// - pad 1 codes 0-4 route row marker, delayed power-on, power-on, row connect and clamp.
// - pad 1 codes 6-10 route pre-clamp, post-clamp, delayed analog, read and calibration markers.
// - pad 1 code 11 is half clock, 12 analog marker, 13 latch, 14 high, 5 and 15 low.
// - pad 2 codes 0-6 route sequencer timing, codes 8-15 the line/frame/clamp/reset and mux sync signals.
// - pad 2 code 7 outputs the main clock divided by 16.
// - pad disable bits 6..0 turn off start, speak, pll, data1, data0, marker and clock pads.
// - analog control bits 7-6 choose discriminator group A to D for monitoring.
// - bit 5 enables analog mux, 4 read delay, 3 disables pixel clamp, 2 enables command gen.
// - bit 1 selects the output sampling clock, 0 for 80 MHz and 1 for 160 MHz.
// - with bit 0 clear data uses line 1 only and line 0 stays low, set uses both lines.
// - test mode bit 7 enables test pads, 6 line discriminator, 5 clock gating, 4 unused.
// - test mode bits 3..0 enable mux scan, discriminator scan, general scan and autoscan.
// - the power reset clears all four registers to zero.
// - registers load only through the serial slave port and ignore the start reset.
module rmc_readout_cfg (
  // clock and reset
  input  wire                  core_clk_i,
  input  wire                  nrst_i,
  // serial slow-control port, already in the core clock domain
  input  wire [`RMC_IR_W-1:0]  tap_instr_i,
  input  wire                  tap_capture_i,
  input  wire                  tap_shift_i,
  input  wire                  tap_update_i,
  input  wire                  tap_tdi_i,
  output reg                   tap_tdo_o,
  // selectable internal signals
  input  wire                  digital_row_marker_i,
  input  wire                  power_on_delayed_i,
  input  wire                  power_on_i,
  input  wire                  row_connect_i,
  input  wire                  clamp_i,
  input  wire                  pre_clamp_strobe_i,
  input  wire                  post_clamp_strobe_i,
  input  wire                  delayed_analog_marker_i,
  input  wire                  read_phase_marker_i,
  input  wire                  calibration_phase_marker_i,
  input  wire                  analog_sequence_marker_i,
  input  wire                  disc_latch_i,
  input  wire [6:0]            zs_timing_i,
  input  wire                  line_start_i,
  input  wire                  line_reset_i,
  input  wire                  frame_start_i,
  input  wire                  frame_reset_i,
  input  wire                  pixel_reset_i,
  input  wire                  mux_sync_i,
  input  wire                  seq_reset_i,
  // test pads
  output wire                  test_pad1_o,
  output wire                  test_pad2_o,
  // pad disables
  output reg                   start_pad_off_o,
  output reg                   speak_pad_off_o,
  output reg                   pll_pad_off_o,
  output reg                   data1_pad_off_o,
  output reg                   data0_pad_off_o,
  output reg                   marker_pad_off_o,
  output reg                   clock_pad_off_o,
  // analog and output options
  output reg  [1:0]            disc_group_o,
  output reg                   anamux_en_o,
  output reg                   read_delay_en_o,
  output reg                   pixel_clamp_off_o,
  output reg                   cmdgen_cfg_en_o,
  output reg                   rate_160_o,
  output reg                   dual_line_o,
  // test modes
  output reg                   test_pad_en_o,
  output reg                   disc_line_en_o,
  output reg                   clock_gating_en_o,
  output reg                   mux_scan_en_o,
  output reg                   disc_scan_en_o,
  output reg                   scan_en_o,
  output reg                   disc_autoscan_en_o
);
  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_meta;
  reg rst_n;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and shift stage
  reg  [`RMC_REG_W-1:0] test_pad_select;
  reg  [`RMC_REG_W-1:0] pad_disable_control;
  reg  [`RMC_REG_W-1:0] analog_output_control;
  reg  [`RMC_REG_W-1:0] test_mode_control;
  reg  [`RMC_REG_W-1:0] shift_reg;
  reg  [`RMC_REG_W-1:0] sel_value;
  wire                  sel_hit;

  assign sel_hit = (tap_instr_i == `RMC_IR_PADSEL) || (tap_instr_i == `RMC_IR_PADDIS) ||
                   (tap_instr_i == `RMC_IR_ANAOUT) || (tap_instr_i == `RMC_IR_TSTMODE);

  // register currently selected by the instruction, zero when none
  always @* begin
    case (tap_instr_i)
      `RMC_IR_PADSEL:  sel_value = test_pad_select;
      `RMC_IR_PADDIS:  sel_value = pad_disable_control;
      `RMC_IR_ANAOUT:  sel_value = analog_output_control;
      `RMC_IR_TSTMODE: sel_value = test_mode_control;
      default:         sel_value = `RMC_RST_VAL;
    endcase
  end

  // capture loads the selected value, zero for a refused instruction, so a stale
  // shift stage never leaks out; shift moves lsb first toward tdo
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= `RMC_RST_VAL;
      tap_tdo_o <= 1'b0;
    end else begin
      if (tap_capture_i) begin
        shift_reg <= sel_value;
      end else if (tap_shift_i && sel_hit) begin
        shift_reg <= {tap_tdi_i, shift_reg[`RMC_REG_W-1:1]};
      end
      tap_tdo_o <= shift_reg[0];
    end
  end

  // only the power reset clears them; the start reset never reaches here
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      test_pad_select       <= `RMC_RST_VAL;
      pad_disable_control   <= `RMC_RST_VAL;
      analog_output_control <= `RMC_RST_VAL;
      test_mode_control     <= `RMC_RST_VAL;
    end else if (tap_update_i) begin
      case (tap_instr_i)
        `RMC_IR_PADSEL:  test_pad_select       <= shift_reg;
        `RMC_IR_PADDIS:  pad_disable_control   <= shift_reg;
        `RMC_IR_ANAOUT:  analog_output_control <= shift_reg;
        `RMC_IR_TSTMODE: test_mode_control     <= shift_reg;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded control outputs, registered so each comes from a flip-flop
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      {start_pad_off_o, speak_pad_off_o, pll_pad_off_o, data1_pad_off_o} <= 4'h0;
      {data0_pad_off_o, marker_pad_off_o, clock_pad_off_o} <= 3'h0;
      disc_group_o <= 2'h0;
      {anamux_en_o, read_delay_en_o, pixel_clamp_off_o, cmdgen_cfg_en_o} <= 4'h0;
      {rate_160_o, dual_line_o} <= 2'h0;
      {test_pad_en_o, disc_line_en_o, clock_gating_en_o} <= 3'h0;
      {mux_scan_en_o, disc_scan_en_o, scan_en_o, disc_autoscan_en_o} <= 4'h0;
    end else begin
      start_pad_off_o    <= pad_disable_control[`RMC_DIS_START];
      speak_pad_off_o    <= pad_disable_control[`RMC_DIS_SPEAK];
      pll_pad_off_o      <= pad_disable_control[`RMC_DIS_PLL];
      data1_pad_off_o    <= pad_disable_control[`RMC_DIS_DATA1];
      // single-line mode keeps data line 0 low by parking its pad
      data0_pad_off_o    <= pad_disable_control[`RMC_DIS_DATA0] |
                            ~analog_output_control[`RMC_ANA_DUAL];
      marker_pad_off_o   <= pad_disable_control[`RMC_DIS_MARKER];
      clock_pad_off_o    <= pad_disable_control[`RMC_DIS_CLK];
      disc_group_o       <= analog_output_control[`RMC_ANA_GRP_HI:`RMC_ANA_GRP_LO];
      anamux_en_o        <= analog_output_control[`RMC_ANA_MUX];
      read_delay_en_o    <= analog_output_control[`RMC_ANA_RDDLY];
      pixel_clamp_off_o  <= analog_output_control[`RMC_ANA_NOCLP];
      cmdgen_cfg_en_o    <= analog_output_control[`RMC_ANA_CMDGEN];
      rate_160_o         <= analog_output_control[`RMC_ANA_RATE];
      dual_line_o        <= analog_output_control[`RMC_ANA_DUAL];
      test_pad_en_o      <= test_mode_control[`RMC_TM_PADEN];
      disc_line_en_o     <= test_mode_control[`RMC_TM_DISCLINE];
      clock_gating_en_o  <= test_mode_control[`RMC_TM_GATECK];
      mux_scan_en_o      <= test_mode_control[`RMC_TM_MUXSCAN];
      disc_scan_en_o     <= test_mode_control[`RMC_TM_DISCSCAN];
      scan_en_o          <= test_mode_control[`RMC_TM_SCAN];
      disc_autoscan_en_o <= test_mode_control[`RMC_TM_AUTOSCAN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local clock dividers for the pads: half rate and divide by 16
  reg [`RMC_DIV_W-1:0] div_cnt;
  reg                  half_rate_clock;
  reg                  divided_main_clock;
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt            <= {`RMC_DIV_W{1'b0}};
      half_rate_clock    <= 1'b0;
      divided_main_clock <= 1'b0;
    end else begin
      div_cnt            <= div_cnt + 1'b1;
      half_rate_clock    <= ~half_rate_clock;
      // high for 8 of every 16 cycles
      divided_main_clock <= (div_cnt > `RMC_DIV_HALF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source tables; constants tie the ground and supply codes
  wire [15:0] pad1_sources;
  wire [15:0] pad2_sources;
  wire [3:0]  pad1_source_code;
  wire [3:0]  pad2_source_code;

  assign pad1_source_code = test_pad_select[`RMC_PAD1_HI:`RMC_PAD1_LO];
  assign pad2_source_code = test_pad_select[`RMC_PAD2_HI:`RMC_PAD2_LO];

  assign pad1_sources = {1'b0, 1'b1, disc_latch_i, analog_sequence_marker_i,
                         half_rate_clock, calibration_phase_marker_i,
                         read_phase_marker_i, delayed_analog_marker_i,
                         post_clamp_strobe_i, pre_clamp_strobe_i, 1'b0,
                         clamp_i, row_connect_i, power_on_i,
                         power_on_delayed_i, digital_row_marker_i};
  assign pad2_sources = {seq_reset_i, mux_sync_i, pixel_reset_i, clamp_i,
                         frame_reset_i, frame_start_i, line_reset_i, line_start_i,
                         divided_main_clock, zs_timing_i};

  // the enable bit forces both pads low when test pads are off
  rmc_pad_mux u_pad1 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .code_i     (pad1_source_code),
    .enable_i   (test_mode_control[`RMC_TM_PADEN]),
    .sources_i  (pad1_sources),
    .pad_o      (test_pad1_o)
  );

  rmc_pad_mux u_pad2 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .code_i     (pad2_source_code),
    .enable_i   (test_mode_control[`RMC_TM_PADEN]),
    .sources_i  (pad2_sources),
    .pad_o      (test_pad2_o)
  );
endmodule

// [sim/rmc_host_model.sv]
`timescale 1ns/1ps
// slow-control host: one capture, eight shifts, one update per transfer
module rmc_host_model (
  // clock and serial return
  input  logic       core_clk_i,
  input  logic       tap_tdo_o,
  // slave port requests
  output logic [2:0] tap_instr_i,
  output logic       tap_capture_i,
  output logic       tap_shift_i,
  output logic       tap_update_i,
  output logic       tap_tdi_i
);
  localparam logic [7:0] ANA_NORMAL = 8'h37; // dual line at 160 MHz

  // idle port at time zero
  initial begin
    tap_instr_i = 3'h0;
    tap_capture_i = 1'b0;
    tap_shift_i = 1'b0;
    tap_update_i = 1'b0;
    tap_tdi_i = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writes w and returns the old contents; lsb travels first both ways
  task automatic xfer(input logic [2:0] c, input logic [7:0] w, output logic [7:0] r);
    @(posedge core_clk_i);
    tap_instr_i <= c;
    tap_capture_i <= 1'b1;
    @(posedge core_clk_i);
    tap_capture_i <= 1'b0;
    tap_shift_i <= 1'b1;
    tap_tdi_i <= w[0];
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_i);
      if (i < 7) tap_tdi_i <= w[i+1];
      else begin
        tap_shift_i <= 1'b0;
        tap_update_i <= 1'b1;
        tap_tdi_i <= ~w[7]; // no stale bit left on the line
      end
      @(negedge core_clk_i);
      r[i] = tap_tdo_o;
    end
    @(posedge core_clk_i);
    tap_update_i <= 1'b0;
  endtask
endmodule

// [sim/rmc_readout_cfg_properties.sv]
`timescale 1ns/1ps
`include "rmc_consts.vh"
module rmc_cfg_checker (
  // slave port
  input logic [2:0] tap_instr_i,
  input logic core_clk_i, nrst_i, tap_capture_i, tap_shift_i, tap_update_i, tap_tdi_i,
  // pads
  input logic line_start_i, test_pad1_o, test_pad2_o,
  // register copies
  input logic start_pad_off_o, speak_pad_off_o, pll_pad_off_o, data1_pad_off_o,
  input logic data0_pad_off_o, marker_pad_off_o, clock_pad_off_o, anamux_en_o,
  input logic [1:0] disc_group_o,
  input logic read_delay_en_o, pixel_clamp_off_o, cmdgen_cfg_en_o, rate_160_o, dual_line_o,
  input logic test_pad_en_o, disc_line_en_o, clock_gating_en_o, mux_scan_en_o,
  input logic disc_scan_en_o, scan_en_o, disc_autoscan_en_o
);
  logic [7:0] sh, upd, sel;
  logic [2:0] up;
  wire [5:0] pd = {start_pad_off_o, speak_pad_off_o, pll_pad_off_o, data1_pad_off_o,
                   marker_pad_off_o, clock_pad_off_o};
  wire [7:0] ana = {disc_group_o, anamux_en_o, read_delay_en_o, pixel_clamp_off_o,
                    cmdgen_cfg_en_o, rate_160_o, dual_line_o};
  wire [6:0] tm = {test_pad_en_o, disc_line_en_o, clock_gating_en_o, mux_scan_en_o,
                   disc_scan_en_o, scan_en_o, disc_autoscan_en_o};

  // shadow of the shift stage, so expected values never come from the design
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh <= 8'h00;
      upd <= 8'h00;
      sel <= 8'h00;
      up <= 3'h0;
    end else begin
      if (!up[2]) up <= up + 3'h1;
      if (tap_shift_i && !tap_capture_i) sh <= {tap_tdi_i, sh[7:1]};
      if (tap_update_i) upd <= sh;
      if (tap_update_i && tap_instr_i == `RMC_IR_PADSEL) sel <= sh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence load_s(logic [2:0] c);
    tap_update_i && tap_instr_i == c;
  endsequence
  sequence held_s(logic [7:0] m, logic [7:0] v);
    (test_pad_en_o && (sel & m) == v)[*3];
  endsequence

  rst_clears_a: assert property (disable iff (1'b0)
    !nrst_i |-> tm == 7'h00 && ana == 8'h00 && pd == 6'h00) else $error("not cleared");
  pad_disable_a: assert property (
    load_s(`RMC_IR_PADDIS) |-> ##2 pd == {upd[6:3], upd[1:0]}) else $error("pad off");
  ana_write_a: assert property (
    load_s(`RMC_IR_ANAOUT) |-> ##2 ana == upd) else $error("analog control");
  test_mode_a: assert property (
    load_s(`RMC_IR_TSTMODE) |-> ##2 tm == {upd[7:5], upd[3:0]}) else $error("test mode");
  single_line_a: assert property (
    up[2] && !dual_line_o && !$past(dual_line_o) |-> data0_pad_off_o) else $error("line 0");
  pads_quiet_a: assert property (
    (!test_pad_en_o)[*3] |-> !test_pad1_o && !test_pad2_o) else $error("pads not low");
  pad1_high_a: assert property (
    held_s(8'hF0, 8'hE0) |-> test_pad1_o) else $error("pad1 not high");
  pad2_route_a: assert property (
    held_s(8'h0F, 8'h08) |-> test_pad2_o == $past(line_start_i, 1)) else $error("pad2 route");
endmodule

bind rmc_readout_cfg rmc_cfg_checker rmc_cfg_checker_i (.*);

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "rmc_consts.vh"
module testbench;
  logic core_clk_i, nrst_i;
  logic [15:0] src;
  int fails = 0, n_checks = 0;
  wire [2:0] tap_instr_i;
  wire tap_capture_i, tap_shift_i, tap_update_i, tap_tdi_i, tap_tdo_o, test_pad1_o, test_pad2_o;
  wire start_pad_off_o, speak_pad_off_o, pll_pad_off_o, data1_pad_off_o, data0_pad_off_o;
  wire marker_pad_off_o, clock_pad_off_o, anamux_en_o, read_delay_en_o, pixel_clamp_off_o;
  wire cmdgen_cfg_en_o, rate_160_o, dual_line_o, test_pad_en_o, disc_line_en_o, scan_en_o;
  wire clock_gating_en_o, mux_scan_en_o, disc_scan_en_o, disc_autoscan_en_o;
  wire [1:0] disc_group_o;
  // one source vector; clamp feeds pad 1 code 4 and pad 2 code 12
  wire digital_row_marker_i = src[0], power_on_delayed_i = src[1], power_on_i = src[2];
  wire row_connect_i = src[3], clamp_i = src[4] | src[12], pre_clamp_strobe_i = src[6];
  wire post_clamp_strobe_i = src[7], delayed_analog_marker_i = src[8];
  wire read_phase_marker_i = src[9], calibration_phase_marker_i = src[10];
  wire analog_sequence_marker_i = src[12], disc_latch_i = src[13];
  wire [6:0] zs_timing_i = src[6:0];
  wire line_start_i = src[8], line_reset_i = src[9], frame_start_i = src[10];
  wire frame_reset_i = src[11], pixel_reset_i = src[13], mux_sync_i = src[14];
  wire seq_reset_i = src[15];
  wire [7:0] pd_v = {1'b0, start_pad_off_o, speak_pad_off_o, pll_pad_off_o, data1_pad_off_o,
                     data0_pad_off_o, marker_pad_off_o, clock_pad_off_o};
  wire [7:0] ana_v = {disc_group_o, anamux_en_o, read_delay_en_o, pixel_clamp_off_o,
                      cmdgen_cfg_en_o, rate_160_o, dual_line_o};
  wire [7:0] tm_v = {test_pad_en_o, disc_line_en_o, clock_gating_en_o, 1'b0, mux_scan_en_o,
                     disc_scan_en_o, scan_en_o, disc_autoscan_en_o};

  rmc_readout_cfg rmc_readout_cfg_i (.*);
  rmc_host_model rmc_host_model_i (.*);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic xfer(input logic [2:0] c, input logic [7:0] w, output logic [7:0] r);
    rmc_host_model_i.xfer(c, w, r);
  endtask

  // register writes, readback, single-line forcing and refused instructions
  task automatic t_regs;
    logic [7:0] r;
    xfer(`RMC_IR_PADDIS, 8'h7F, r); chk("dis rb", 8'h00, r);
    settle(3); chk("dis", 8'h7F, pd_v);
    xfer(`RMC_IR_PADDIS, 8'h2A, r); chk("dis rb", 8'h7F, r);
    settle(3); chk("dis single", 8'h2E, pd_v);
    xfer(`RMC_IR_ANAOUT, 8'hC8, r); chk("ana rb", 8'h00, r);
    settle(3); chk("ana", 8'hC8, ana_v);
    xfer(`RMC_IR_ANAOUT, rmc_host_model_i.ANA_NORMAL, r); chk("ana rb", 8'hC8, r);
    settle(3); chk("ana", 8'h37, ana_v);
    chk("dis dual", 8'h2A, pd_v);
    xfer(`RMC_IR_TSTMODE, 8'h7F, r); chk("tm rb", 8'h00, r);
    settle(3); chk("tm", 8'h6F, tm_v);
    foreach (r[i]) if (i == 0 || i > 4) begin
      xfer(i[2:0], 8'hFF, r); chk("refused rb", 8'h00, r);
    end
    settle(3); chk("ana kept", 8'h37, ana_v);
  endtask

  // every selection code of both pads
  task automatic t_pads;
    logic [7:0] r, c1, c2;
    xfer(`RMC_IR_PADSEL, 8'hEE, r); chk("sel rb", 8'h00, r);
    src <= 16'hFFFF;
    settle(4); chk("pads off", 8'h00, {test_pad1_o, test_pad2_o});
    xfer(`RMC_IR_TSTMODE, 8'h80, r);
    for (int k = 0; k < 16; k++) begin
      xfer(`RMC_IR_PADSEL, {k[3:0], k[3:0]}, r);
      src <= 16'h0000;
      settle(4); chk("pads zero", {k == 14, 1'b0}, {test_pad1_o & (k != 11), test_pad2_o & (k != 7)});
      @(posedge core_clk_i);
      src <= 16'h0001 << k;
      settle(4); chk("pads one", {k != 5 && k != 15, 1'b1} & {k != 11, k != 7}, {test_pad1_o & (k != 11), test_pad2_o & (k != 7)});
    end
    xfer(`RMC_IR_PADSEL, 8'hB7, r); chk("sel rb", 8'hFF, r);
    // let the new codes reach the pads before counting edges
    settle(2);
    {c1, c2} = 16'h0000;
    repeat (64) begin
      r = {test_pad1_o, test_pad2_o};
      settle(1);
      c1 += (r[1] != test_pad1_o);
      c2 += (r[0] != test_pad2_o);
    end
    chk("half clock", 8'h40, c1);
    chk("div 16", 8'h08, c2);
  endtask

  // power reset in mid-run clears every register and output
  task automatic t_reset;
    logic [7:0] r;
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    settle(2);
    chk("ana reset", 8'h00, ana_v);
    chk("dis reset", 8'h00, pd_v);
    chk("tm reset", 8'h00, tm_v);
    chk("pads reset", 8'h00, {test_pad1_o, test_pad2_o});
    @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    xfer(`RMC_IR_ANAOUT, 8'h37, r); chk("ana rb reset", 8'h00, r);
    xfer(`RMC_IR_TSTMODE, 8'h00, r); chk("tm rb reset", 8'h00, r);
    xfer(`RMC_IR_PADSEL, 8'h00, r); chk("sel rb reset", 8'h00, r);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // 200 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  // main sequence: five cycles of reset, then the scenarios
  initial begin
    // start high so the fall at 1 ns is a clean edge that every process sees
    nrst_i = 1'b1;
    src = 16'h0000;
    #1;
    nrst_i = 1'b0;
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_regs;
    t_pads;
    t_reset;
    tally_and_finish;
  end

  // watchdog well beyond the roughly 600 cycles the scenarios need
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
endmodule
